// ### tocu_device.sv
`timescale 1ns/1ps
`default_nettype none
module tocu_device
   import tocu_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // cpu register bus
   tocu_io_if.dev io,
   // counter side
   input wire logic [CNT_W-1:0] timer_count_value,
   input wire logic timer_tick,
   input wire logic count_written,
   input wire logic counter_at_top,
   input wire logic counter_at_bottom,
   input wire logic count_down,
   input wire logic [WGM_W-1:0] waveform_gen_select,
   // interrupt side
   input wire logic [NCH-1:0] irq_ack,
   output logic [NCH-1:0] compare_irq_req,
   // waveform outputs and top value
   output logic [NCH-1:0] compare_output_state,
   output logic [CNT_W-1:0] compare_top_value
);

   typedef struct packed {
      logic [NCH-1:0][CNT_W-1:0] ocr;
      logic [NCH-1:0][CNT_W-1:0] cbuf;
      logic [BYTE_W-1:0] temp;
      logic [NCH-1:0][ACT_W-1:0] act;
      logic [NCH-1:0] irq_en;
      logic [NCH-1:0] flag;
      logic [NCH-1:0] oc;
      logic block;
      logic [BYTE_W-1:0] rdata;
   } tocu_dev_state_t;

   tocu_dev_state_t s_q;
   tocu_dev_state_t s_d;

   logic buffered;
   logic fast_pwm;
   logic bottom_load;
   logic load_pt;
   logic wr_ctrl;
   logic wr_irqen;
   logic wr_flags;
   logic [NCH-1:0] hit;
   logic [NCH-1:0] force_hit;
   logic [NCH-1:0] wr_low;
   logic [NCH-1:0] wr_high;
   logic [NCH-1:0] oc_nxt;

   // mode decode; reserved code treated as unbuffered, no pwm
   always_comb
   begin
      buffered = 1'b1;
      fast_pwm = 1'b0;
      bottom_load = 1'b0;
      case (waveform_gen_select)
         WGM_NORMAL, WGM_CTC_OCR, WGM_CTC_ICR, WGM_RSVD: buffered = 1'b0;
         WGM_FAST_8, WGM_FAST_9, WGM_FAST_10, WGM_FAST_ICR, WGM_FAST_OCR: fast_pwm = 1'b1;
         WGM_PFC_ICR, WGM_PFC_OCR: bottom_load = 1'b1;
         default: ;
      endcase
   end

   // update point of the double buffer
   assign load_pt = buffered & timer_tick
      & (bottom_load ? counter_at_bottom : counter_at_top);

   // register bus decode
   assign wr_ctrl = io.io_wr & (io.io_addr == IO_CTRL);
   assign wr_irqen = io.io_wr & (io.io_addr == IO_IRQ_EN);
   assign wr_flags = io.io_wr & (io.io_addr == IO_FLAGS);

   // per-channel compare and waveform logic
   generate
      for (genvar i = 0; i < NCH; i++)
      begin : g_ch
         logic oc_n;

         assign wr_low[i] = io.io_wr & (io.io_addr == LOW_ADDR[i]);
         assign wr_high[i] = io.io_wr & (io.io_addr == HIGH_ADDR[i]);
         // a count write suppresses matches for one timer cycle
         assign hit[i] = timer_tick & ~s_q.block
            & (timer_count_value == s_q.ocr[i]);
         // force only counts outside pwm modes
         assign force_hit[i] = wr_ctrl & io.io_wdata[FORCE_POS0-i] & ~buffered;

         // next output state; action read live from the register
         always_comb
         begin
            oc_n = s_q.oc[i];
            if (!buffered)
            begin
               if (hit[i] | force_hit[i])
               begin
                  case (s_q.act[i])
                     ACT_TOGGLE: oc_n = ~s_q.oc[i];
                     ACT_CLEAR: oc_n = 1'b0;
                     ACT_SET: oc_n = 1'b1;
                     default: ;
                  endcase
               end
            end
            else if (hit[i])
            begin
               case (s_q.act[i])
                  ACT_TOGGLE: oc_n = ~s_q.oc[i];
                  ACT_CLEAR: oc_n = fast_pwm ? 1'b0 : count_down;
                  ACT_SET: oc_n = fast_pwm ? 1'b1 : ~count_down;
                  default: ;
               endcase
            end
            else if (fast_pwm & timer_tick & counter_at_top)
            begin
               // fast pwm restarts the pulse at the extreme value
               case (s_q.act[i])
                  ACT_CLEAR: oc_n = 1'b1;
                  ACT_SET: oc_n = 1'b0;
                  default: ;
               endcase
            end
         end

         assign oc_nxt[i] = oc_n;
      end
   endgenerate

   // next state of the whole unit
   always_comb
   begin
      logic [BYTE_W-1:0] ctrl_rd;
      logic [CNT_W-1:0] view;
      ctrl_rd = BYTE_RST;
      view = CMP_RST;
      s_d = s_q;
      s_d.rdata = BYTE_RST;
      // set wins so a write in the tick cycle still blocks
      if (count_written)
      begin
         s_d.block = 1'b1;
      end
      else if (timer_tick)
      begin
         s_d.block = 1'b0;
      end
      for (int i = 0; i < NCH; i++)
      begin
         // the high byte location only fills the shared latch
         if (wr_high[i])
         begin
            s_d.temp = io.io_wdata;
         end
         if (load_pt)
         begin
            s_d.ocr[i] = s_q.cbuf[i];
         end
         if (wr_low[i])
         begin
            if (buffered)
            begin
               s_d.cbuf[i] = {s_q.temp, io.io_wdata};
            end
            else
            begin
               s_d.ocr[i] = {s_q.temp, io.io_wdata};
            end
         end
         if (wr_ctrl)
         begin
            s_d.act[i] = io.io_wdata[ACT_POS0-ACT_STEP*i +: ACT_W];
         end
         if (wr_irqen)
         begin
            s_d.irq_en[i] = io.io_wdata[i];
         end
         // set wins over a clear in the same cycle
         if (irq_ack[i] | (wr_flags & io.io_wdata[i]))
         begin
            s_d.flag[i] = 1'b0;
         end
         if (hit[i])
         begin
            s_d.flag[i] = 1'b1;
         end
         s_d.oc[i] = oc_nxt[i];
         ctrl_rd[ACT_POS0-ACT_STEP*i +: ACT_W] = s_q.act[i];
         // reads skip the latch: the value only changes on writes
         view = buffered ? s_q.cbuf[i] : s_q.ocr[i];
         if (io.io_rd & (io.io_addr == LOW_ADDR[i]))
         begin
            s_d.rdata = view[BYTE_W-1:0];
         end
         if (io.io_rd & (io.io_addr == HIGH_ADDR[i]))
         begin
            s_d.rdata = view[CNT_W-1:BYTE_W];
         end
      end
      if (io.io_rd)
      begin
         case (io.io_addr)
            IO_CTRL: s_d.rdata = ctrl_rd;
            IO_IRQ_EN: s_d.rdata = {{(BYTE_W-NCH){1'b0}}, s_q.irq_en};
            IO_FLAGS: s_d.rdata = {{(BYTE_W-NCH){1'b0}}, s_q.flag};
            default: ;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q.ocr <= {NCH{CMP_RST}};
         s_q.cbuf <= {NCH{CMP_RST}};
         s_q.temp <= BYTE_RST;
         s_q.act <= {NCH{ACT_RST}};
         s_q.irq_en <= '0;
         s_q.flag <= '0;
         s_q.oc <= {NCH{OUT_RST}};
         s_q.block <= 1'b0;
         s_q.rdata <= BYTE_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs
   assign io.io_rdata = s_q.rdata;
   assign compare_irq_req = s_q.flag & s_q.irq_en;
   assign compare_output_state = s_q.oc;
   assign compare_top_value = s_q.ocr[0];
endmodule
`default_nettype wire

// ### tocu_pkg.sv
`default_nettype none
package tocu_pkg;
   // widths and channel count
   localparam int CNT_W = 16;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 3;
   localparam int WGM_W = 4;
   localparam int ACT_W = 2;
   localparam int NCH = 2;

   // device byte-wide i/o locations
   localparam logic [ADDR_W-1:0] IO_CMPA_LOW = 3'h0;
   localparam logic [ADDR_W-1:0] IO_CMPA_HIGH = 3'h1;
   localparam logic [ADDR_W-1:0] IO_CMPB_LOW = 3'h2;
   localparam logic [ADDR_W-1:0] IO_CMPB_HIGH = 3'h3;
   localparam logic [ADDR_W-1:0] IO_CTRL = 3'h4;
   localparam logic [ADDR_W-1:0] IO_IRQ_EN = 3'h5;
   localparam logic [ADDR_W-1:0] IO_FLAGS = 3'h6;
   localparam logic [NCH-1:0][ADDR_W-1:0] LOW_ADDR = {IO_CMPB_LOW, IO_CMPA_LOW};
   localparam logic [NCH-1:0][ADDR_W-1:0] HIGH_ADDR = {IO_CMPB_HIGH, IO_CMPA_HIGH};

   // control byte layout: action of channel i at ACT_POS0-ACT_STEP*i, force at FORCE_POS0-i
   localparam int ACT_POS0 = 6;
   localparam int ACT_STEP = 2;
   localparam int FORCE_POS0 = 3;

   // compare output actions
   localparam logic [ACT_W-1:0] ACT_NONE = 2'h0;
   localparam logic [ACT_W-1:0] ACT_TOGGLE = 2'h1;
   localparam logic [ACT_W-1:0] ACT_CLEAR = 2'h2;
   localparam logic [ACT_W-1:0] ACT_SET = 2'h3;

   // waveform generation select codes
   localparam logic [WGM_W-1:0] WGM_NORMAL = 4'h0;
   localparam logic [WGM_W-1:0] WGM_CTC_OCR = 4'h4;
   localparam logic [WGM_W-1:0] WGM_CTC_ICR = 4'hC;
   localparam logic [WGM_W-1:0] WGM_RSVD = 4'hD;
   localparam logic [WGM_W-1:0] WGM_FAST_8 = 4'h5;
   localparam logic [WGM_W-1:0] WGM_FAST_9 = 4'h6;
   localparam logic [WGM_W-1:0] WGM_FAST_10 = 4'h7;
   localparam logic [WGM_W-1:0] WGM_FAST_ICR = 4'hE;
   localparam logic [WGM_W-1:0] WGM_FAST_OCR = 4'hF;
   localparam logic [WGM_W-1:0] WGM_PFC_ICR = 4'h8;
   localparam logic [WGM_W-1:0] WGM_PFC_OCR = 4'h9;

   // reset values
   localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
   localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
   localparam logic [ACT_W-1:0] ACT_RST = ACT_NONE;
   localparam logic OUT_RST = 1'b0;

   // host command port addresses
   localparam logic [ADDR_W-1:0] CMD_WR_A = 3'h0;
   localparam logic [ADDR_W-1:0] CMD_WR_B = 3'h1;
   localparam logic [ADDR_W-1:0] CMD_WR_BYTE = 3'h2;
   localparam logic [ADDR_W-1:0] CMD_RD = 3'h3;
   localparam logic [ADDR_W-1:0] CMD_STATUS = 3'h4;
   localparam logic [ADDR_W-1:0] CMD_RESULT = 3'h5;
   localparam int CMD_BYTE_ADDR_POS = 8;
endpackage
`default_nettype wire

// ### tocu_io_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tocu_io_if;
   import tocu_pkg::*;
   // byte-wide register bus, read data one cycle after the strobe
   logic [ADDR_W-1:0] io_addr;
   logic [BYTE_W-1:0] io_wdata;
   logic io_wr;
   logic io_rd;
   logic [BYTE_W-1:0] io_rdata;

   modport dev (
      input io_addr,
      input io_wdata,
      input io_wr,
      input io_rd,
      output io_rdata
   );

   modport host (
      output io_addr,
      output io_wdata,
      output io_wr,
      output io_rd,
      input io_rdata
   );
endinterface
`default_nettype wire

// ### tocu_host.sv
`timescale 1ns/1ps
`default_nettype none
module tocu_host
   import tocu_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // software command port
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [CNT_W-1:0] cmd_wdata,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [CNT_W-1:0] cmd_rdata,
   // device register bus
   tocu_io_if.host io
);

   typedef enum logic [5:0] {
      H_IDLE = 6'h01,
      H_WR_HI = 6'h02,
      H_WR_LO = 6'h04,
      H_RD_LO = 6'h08,
      H_RD_HI = 6'h10,
      H_RD_END = 6'h20
   } tocu_host_st_t;

   typedef struct packed {
      tocu_host_st_t st;
      logic [ADDR_W-1:0] target;
      logic wide;
      logic [CNT_W-1:0] data;
      logic [CNT_W-1:0] result;
      logic [ADDR_W-1:0] io_addr;
      logic [BYTE_W-1:0] io_wdata;
      logic io_wr;
      logic io_rd;
      logic [CNT_W-1:0] cmd_rdata;
   } tocu_host_state_t;

   tocu_host_state_t s_q;
   tocu_host_state_t s_d;

   // sequencer; commands while busy are dropped
   always_comb
   begin
      logic rd_wide;
      logic [ADDR_W-1:0] tgt_high;
      logic ch;
      rd_wide = 1'b0;
      tgt_high = s_q.target;
      ch = (cmd_addr == CMD_WR_B);
      for (int j = 0; j < NCH; j++)
      begin
         if (cmd_wdata[ADDR_W-1:0] == LOW_ADDR[j])
         begin
            rd_wide = 1'b1;
         end
         if (s_q.target == LOW_ADDR[j])
         begin
            tgt_high = HIGH_ADDR[j];
         end
      end
      s_d = s_q;
      s_d.io_wr = 1'b0;
      s_d.io_rd = 1'b0;
      s_d.cmd_rdata = CMP_RST;
      case (s_q.st)
         H_IDLE:
         begin
            if (cmd_wr)
            begin
               case (cmd_addr)
                  CMD_WR_A, CMD_WR_B:
                  begin
                     // high byte goes first to fill the device latch
                     s_d.target = LOW_ADDR[ch];
                     s_d.data = cmd_wdata;
                     s_d.io_addr = HIGH_ADDR[ch];
                     s_d.io_wdata = cmd_wdata[CNT_W-1:BYTE_W];
                     s_d.io_wr = 1'b1;
                     s_d.st = H_WR_HI;
                  end
                  CMD_WR_BYTE:
                  begin
                     s_d.io_addr = cmd_wdata[CMD_BYTE_ADDR_POS +: ADDR_W];
                     s_d.io_wdata = cmd_wdata[BYTE_W-1:0];
                     s_d.io_wr = 1'b1;
                     s_d.st = H_WR_LO;
                  end
                  CMD_RD:
                  begin
                     // low byte read first, as for any wide register
                     s_d.target = cmd_wdata[ADDR_W-1:0];
                     s_d.wide = rd_wide;
                     s_d.io_addr = cmd_wdata[ADDR_W-1:0];
                     s_d.io_rd = 1'b1;
                     s_d.st = H_RD_LO;
                  end
                  default: ;
               endcase
            end
         end
         H_WR_HI:
         begin
            s_d.io_addr = s_q.target;
            s_d.io_wdata = s_q.data[BYTE_W-1:0];
            s_d.io_wr = 1'b1;
            s_d.st = H_WR_LO;
         end
         H_WR_LO: s_d.st = H_IDLE;
         H_RD_LO:
         begin
            if (s_q.wide)
            begin
               s_d.io_addr = tgt_high;
               s_d.io_rd = 1'b1;
            end
            s_d.st = H_RD_HI;
         end
         H_RD_HI:
         begin
            s_d.result = {BYTE_RST, io.io_rdata};
            s_d.st = s_q.wide ? H_RD_END : H_IDLE;
         end
         H_RD_END:
         begin
            s_d.result[CNT_W-1:BYTE_W] = io.io_rdata;
            s_d.st = H_IDLE;
         end
         default: s_d.st = H_IDLE;
      endcase
      // software read port, data one cycle after the strobe
      if (cmd_rd)
      begin
         case (cmd_addr)
            CMD_STATUS: s_d.cmd_rdata = {{(CNT_W-1){1'b0}}, (s_q.st != H_IDLE)};
            CMD_RESULT: s_d.cmd_rdata = s_q.result;
            default: ;
         endcase
      end
   end

   // state register
   always_ff @(posedge clock)
   begin
      if (sys_rst)
      begin
         s_q.st <= H_IDLE;
         s_q.target <= IO_CMPA_LOW;
         s_q.wide <= 1'b0;
         s_q.data <= CMP_RST;
         s_q.result <= CMP_RST;
         s_q.io_addr <= IO_CMPA_LOW;
         s_q.io_wdata <= BYTE_RST;
         s_q.io_wr <= 1'b0;
         s_q.io_rd <= 1'b0;
         s_q.cmd_rdata <= CMP_RST;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // outputs
   assign io.io_addr = s_q.io_addr;
   assign io.io_wdata = s_q.io_wdata;
   assign io.io_wr = s_q.io_wr;
   assign io.io_rd = s_q.io_rd;
   assign cmd_rdata = s_q.cmd_rdata;
endmodule
`default_nettype wire

// ### tocu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tocu_monitor
   import tocu_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register bus between the ends
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic [BYTE_W-1:0] io_wdata,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [BYTE_W-1:0] io_rdata,
   // counter side and outputs
   input wire logic timer_tick,
   input wire logic count_written,
   input wire logic counter_at_top,
   input wire logic [WGM_W-1:0] waveform_gen_select,
   input wire logic [NCH-1:0] compare_irq_req,
   input wire logic [NCH-1:0] compare_output_state,
   input wire logic [CNT_W-1:0] compare_top_value
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // read data only in the cycle after a strobe, else zero
   AST_RD_ONE_CYCLE: assert property (!$past(io_rd) |-> io_rdata == BYTE_RST)
      else $error("read data outside its cycle");
   AST_ONE_STROBE: assert property (!(io_wr && io_rd))
      else $error("write and read strobe together");
   // a low write must come right after the high write of that channel
   AST_HIGH_FIRST: assert property ((io_wr && !io_addr[2] && !io_addr[0])
      |-> $past(io_wr) && $past(io_addr) == (io_addr | 3'h1))
      else $error("low byte written without high byte before");
   AST_LOW_FIRST: assert property ((io_rd && !io_addr[2] && io_addr[0])
      |-> $past(io_rd) && $past(io_addr) == (io_addr & 3'h6))
      else $error("high byte read without low byte before");
   // normal mode, channel a: latched high and low land in the same cycle
   AST_DIRECT_LOAD: assert property ((io_wr && io_addr == IO_CMPA_LOW
      && waveform_gen_select == WGM_NORMAL)
      |=> compare_top_value == {$past(io_wdata, 2), $past(io_wdata)})
      else $error("direct compare value not merged");
   // in fast pwm with top at ocr, the buffered value may only move to the active one at top
   AST_BUF_AT_TOP: assert property (($changed(compare_top_value)
      && $past(waveform_gen_select) == WGM_FAST_OCR)
      |-> $past(timer_tick && counter_at_top))
      else $error("active value changed away from top");
   AST_BLOCKED: assert property ((count_written ##1 (timer_tick && !io_wr))
      |=> $stable(compare_output_state))
      else $error("match after count write not blocked");
   // without a tick or a write nothing may move the waveform outputs, mode changes included
   AST_QUIET: assert property ((!timer_tick && !io_wr) |=> $stable(compare_output_state))
      else $error("output state moved without cause");
   AST_RESET_CLEAR: assert property (disable iff (1'b0) sys_rst
      |=> compare_output_state == 2'h0 && compare_irq_req == 2'h0
      && compare_top_value == CMP_RST)
      else $error("reset did not clear state");

   // main scenarios
   COV_LOW_WRITE: cover property (io_wr && io_addr == IO_CMPA_LOW);
   COV_OUT_MOVE: cover property ($changed(compare_output_state));
   COV_IRQ: cover property ($rose(compare_irq_req[0]));
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import tocu_pkg::*;
   logic clock;
   logic sys_rst;
   logic [CNT_W-1:0] timer_count_value;
   logic timer_tick, count_written, counter_at_top, counter_at_bottom, count_down;
   logic [WGM_W-1:0] waveform_gen_select;
   logic [NCH-1:0] irq_ack, compare_irq_req, compare_output_state;
   logic [CNT_W-1:0] compare_top_value, cmd_wdata, cmd_rdata, va, vb, vc;
   logic [ADDR_W-1:0] cmd_addr;
   logic cmd_wr, cmd_rd, rd_pend_q;
   logic [NCH-1:0] out_m;
   logic [31:0] seed;
   logic [CNT_W-1:0] exp_q[$];
   int error_cnt, checks_done;

   tocu_io_if u_tocu_io_if ();
   tocu_device u_tocu_device (.clock(clock), .sys_rst(sys_rst), .io(u_tocu_io_if.dev),
      .timer_count_value(timer_count_value), .timer_tick(timer_tick),
      .count_written(count_written), .counter_at_top(counter_at_top),
      .counter_at_bottom(counter_at_bottom), .count_down(count_down),
      .waveform_gen_select(waveform_gen_select), .irq_ack(irq_ack),
      .compare_irq_req(compare_irq_req), .compare_output_state(compare_output_state),
      .compare_top_value(compare_top_value));
   tocu_host u_tocu_host (.clock(clock), .sys_rst(sys_rst), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
      .io(u_tocu_io_if.host));
   tocu_monitor u_tocu_monitor (.clock(clock), .sys_rst(sys_rst),
      .io_addr(u_tocu_io_if.io_addr), .io_wdata(u_tocu_io_if.io_wdata),
      .io_wr(u_tocu_io_if.io_wr), .io_rd(u_tocu_io_if.io_rd),
      .io_rdata(u_tocu_io_if.io_rdata), .timer_tick(timer_tick),
      .count_written(count_written), .counter_at_top(counter_at_top),
      .waveform_gen_select(waveform_gen_select), .compare_irq_req(compare_irq_req),
      .compare_output_state(compare_output_state), .compare_top_value(compare_top_value));

   // 100 MHz clock
   always #5 clock = ~clock;

   task automatic check(input logic [CNT_W-1:0] seen, input logic [CNT_W-1:0] want);
      checks_done++;
      if (seen !== want)
      begin
         error_cnt++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      if (error_cnt == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // xorshift, kept below the idle count so no stray match occurs
   function automatic logic [CNT_W-1:0] rnd15();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return {1'b0, seed[14:0]};
   endfunction

   function automatic logic nxt(input logic o, input logic [ACT_W-1:0] a);
      case (a)
         ACT_TOGGLE: return ~o;
         ACT_CLEAR: return 1'b0;
         ACT_SET: return 1'b1;
         default: return o;
      endcase
   endfunction

   // one command, then wait out the longest busy time
   task automatic cmd(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] d);
      @(posedge clock);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge clock);
      cmd_wr <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic wrb(input logic [ADDR_W-1:0] a, input logic [BYTE_W-1:0] b);
      cmd(CMD_WR_BYTE, {5'h00, a, b});
   endtask

   // read via the host and leave the expected result for the watcher
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [CNT_W-1:0] want);
      cmd(CMD_RD, {13'h0000, a});
      @(posedge clock);
      cmd_addr <= CMD_RESULT;
      cmd_rd <= 1'b1;
      exp_q.push_back(want);
      @(posedge clock);
      cmd_rd <= 1'b0;
   endtask

   // one timer clock cycle; caller stands just after a rising edge
   task automatic tick(input logic [CNT_W-1:0] c, input logic t, input logic b);
      timer_count_value <= c;
      counter_at_top <= t;
      counter_at_bottom <= b;
      timer_tick <= 1'b1;
      @(posedge clock);
      timer_tick <= 1'b0;
      counter_at_top <= 1'b0;
      counter_at_bottom <= 1'b0;
      timer_count_value <= 16'hFFFF;
   endtask

   // result watcher: oldest note against each read answer
   always @(posedge clock)
      rd_pend_q <= cmd_rd;
   always @(negedge clock)
      if (rd_pend_q === 1'b1)
         check(cmd_rdata, exp_q.pop_front());

   // watchdog, far beyond the few hundred cycles needed
   initial
   begin
      repeat (20000) @(posedge clock);
      error_cnt++;
      conclude();
   end

   initial
   begin
      clock = 1'b0;
      sys_rst = 1'b1;
      timer_count_value = 16'hFFFF;
      timer_tick = 1'b0;
      count_written = 1'b0;
      counter_at_top = 1'b0;
      counter_at_bottom = 1'b0;
      count_down = 1'b0;
      waveform_gen_select = WGM_NORMAL;
      irq_ack = 2'h0;
      cmd_addr = 3'h0;
      cmd_wdata = 16'h0000;
      cmd_wr = 1'b0;
      cmd_rd = 1'b0;
      seed = 32'h0000459A;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge clock);
      sys_rst <= 1'b0;
      @(negedge clock);
      check({12'h000, compare_irq_req, compare_output_state}, 16'h0000);
      check(compare_top_value, CMP_RST);
      rd(IO_CMPA_LOW, CMP_RST);
      // direct 16-bit values in normal mode, both channels
      va = rnd15();
      vb = va ^ 16'h0001;
      cmd(CMD_WR_A, va);
      cmd(CMD_WR_B, vb);
      rd(IO_CMPA_LOW, va);
      rd(IO_CMPB_LOW, vb);
      check(compare_top_value, va);
      wrb(3'h7, 8'hFF);
      rd(3'h7, 16'h0000);
      wrb(IO_IRQ_EN, 8'h03);
      rd(IO_IRQ_EN, 16'h0003);
      // every action, first forced, then by a real match
      out_m = 2'h0;
      for (int i = 0; i < 8; i++)
      begin
         wrb(IO_CTRL, {i[1:0], ACT_NONE, 4'h0});
         rd(IO_CTRL, {8'h00, i[1:0], ACT_NONE, 4'h0});
         if (i < 4)
            wrb(IO_CTRL, {i[1:0], ACT_NONE, 4'h8});
         else
            tick(va, 1'b0, 1'b0);
         out_m[0] = nxt(out_m[0], i[1:0]);
         repeat (2) @(negedge clock);
         check({14'h0000, compare_output_state}, {14'h0000, out_m});
         check({14'h0000, compare_irq_req}, {15'h0000, i >= 4});
         rd(IO_FLAGS, {15'h0000, i >= 4});
         @(posedge clock);
         irq_ack <= {1'b0, i[0]};
         @(posedge clock);
         irq_ack <= 2'h0;
         if (!i[0])
            wrb(IO_FLAGS, 8'h01);
         repeat (2) @(negedge clock);
         check({14'h0000, compare_irq_req}, 16'h0000);
      end
      // count write hides the next tick's match, running and stopped
      wrb(IO_CTRL, {ACT_TOGGLE, ACT_NONE, 4'h0});
      for (int g = 0; g < 2; g++)
      begin
         @(posedge clock);
         // count writes only in normal mode, never at a variable top
         timer_count_value <= va;
         count_written <= 1'b1;
         @(posedge clock);
         count_written <= 1'b0;
         repeat (3 * g) @(posedge clock);
         tick(va, 1'b0, 1'b0);
         repeat (2) @(negedge clock);
         check({14'h0000, compare_output_state}, {14'h0000, out_m});
         @(posedge clock);
         tick(va, 1'b0, 1'b0);
         out_m[0] = ~out_m[0];
         repeat (2) @(negedge clock);
         check({14'h0000, compare_output_state}, {14'h0000, out_m});
      end
      // channel b on its own value; a's value differs by one bit
      wrb(IO_CTRL, {ACT_NONE, ACT_SET, 4'h0});
      tick(vb, 1'b0, 1'b0);
      out_m[1] = 1'b1;
      repeat (2) @(negedge clock);
      check({14'h0000, compare_output_state}, {14'h0000, out_m});
      check({14'h0000, compare_irq_req}, 16'h0003);
      rd(IO_FLAGS, 16'h0003);
      // buffered value moves at top in fast mode, at bottom in dual-slope mode
      for (int m = 0; m < 2; m++)
      begin
         @(posedge clock);
         waveform_gen_select <= m[0] ? WGM_PFC_OCR : WGM_FAST_OCR;
         vc = rnd15();
         cmd(CMD_WR_A, vc);
         rd(IO_CMPA_LOW, vc);
         wrb(IO_CTRL, {ACT_TOGGLE, ACT_NONE, 4'h8});
         tick(16'hFFFF, m[0], !m[0]);
         repeat (2) @(negedge clock);
         check(compare_top_value, va);
         check({14'h0000, compare_output_state}, {14'h0000, out_m});
         @(posedge clock);
         tick(16'hFFFF, !m[0], m[0]);
         repeat (2) @(negedge clock);
         check(compare_top_value, vc);
         va = vc;
      end
      // dual-slope clear: match going down sets, match going up clears
      wrb(IO_CTRL, {ACT_CLEAR, ACT_NONE, 4'h0});
      for (int k = 0; k < 2; k++)
      begin
         count_down <= ~k[0];
         tick(va, 1'b0, 1'b0);
         out_m[0] = ~k[0];
         repeat (2) @(negedge clock);
         check({14'h0000, compare_output_state}, {14'h0000, out_m});
         @(posedge clock);
      end
      @(posedge clock);
      waveform_gen_select <= WGM_NORMAL;
      repeat (4) @(negedge clock);
      check({14'h0000, compare_output_state}, {14'h0000, out_m});
      conclude();
   end
endmodule
`default_nettype wire
